// ### src/sde_defs.vh
// Constants for the support director executor
`ifndef SDE_DEFS_VH
`define SDE_DEFS_VH
// Function codes held in director bits 07..00
`define SDE_FN_LOAD_RF   8'h80
`define SDE_FN_KEYPOINT  8'h8A
`define SDE_FN_LOAD_POLY 8'h84
`define SDE_FN_LOAD_HW   8'h86
`define SDE_FN_COPY_STAT 8'h88
// Director field positions
`define SDE_FN_HI        7
`define SDE_FN_LO        0
`define SDE_OPND_HI      23
`define SDE_OPND_LO      8
`define SDE_SEL_DIV_LO   25
`define SDE_SEL_DIV_HI   26
`define SDE_SEL_MUL_LO   27
`define SDE_SEL_MUL_HI   28
`define SDE_ADDR_HI      31
`define SDE_ADDR_LO      28
`define SDE_UNIT_EN      24
`define SDE_HW_PRESET    11
`define SDE_HW_BYTE8     12
`define SDE_HW_ZFILL     15
`define SDE_NOTCH_HI     20
`define SDE_NOTCH_LO     16
// Status word layout
`define SDE_ST_UNIT_HI   5
`define SDE_ST_UNIT_LO   0
`define SDE_ST_SEL_HI    15
`define SDE_ST_SEL_LO    7
// Copy status timing in internal clock pulses
`define SDE_COPY_GATE    4'h7
`define SDE_COPY_WRITE   4'h8
// Keypoint test point pulse, in ns, at 20 MHz
`define SDE_CLK_NS       50
`define SDE_KP_MIN_NS    100
`define SDE_KP_MAX_NS    140
`define SDE_KP_CYCLES    ((`SDE_KP_MIN_NS + `SDE_CLK_NS - 1) / `SDE_CLK_NS)
// Count loaded at pulse start: SDE_KP_CYCLES minus one, at counter width
`define SDE_KP_HOLD      2'h1
// Reset values
`define SDE_ZERO16       16'h0000
`define SDE_ZERO4        4'h0
`define SDE_ZERO5        5'h00
`endif

// ### src/sde_executor.v
// Support director executor: load register file, keypoint, polynomial, hardware, copy status
`timescale 1ns/1ns
`default_nettype none
`include "sde_defs.vh"

// What this block does
// R01: Phase two: done set, operand written, request
// R02: Next phase pair: clear enables, set end flags
// R03: Phase one clears end flag, companion self-clears
// R04: Keypoint captures operand bits into catch register
// R05: Keypoint strobe: low test point 100-140 ns
// R06: Short directors end via honored, done, end
// R07: Code 84 loads polynomial halves from operand
// R08: Bits 25-28 choose divide/multiply halves
// R09: Any select combination loads same operand
// R10: Code 86 strobes hardware and notch registers
// R11: Bit 11 presets else preclears checkword generator
// R12: Bit 12 picks 8-bit else 6-bit mode
// R13: Bit 15 enables zero fill at record end
// R14: Bits 16-20 hold notch count minus one
// R15: Hardware and notch capture together, set honored
// R16: Copy status loads address, starts timing chain
// R17: Bit 24 held; clear zeroes unit status bits
// R18: Unit status bit order sector alert..on-line
// R19: Bits 07-15 carry previously chosen status group
// R20: No drive selected writes all-zero word
// R21: Seventh pulse gates status onto bus
// R22: Eighth pulse writes, stops chain, ends director
// R23: Phase two after strobe drives operand onto bus
// R24: Pending load blocks the next director request
// R25: Phases alternate on system clock, one step each
module sde_executor (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        function_director_decoded,
  input  wire [31:0] director_word,
  input  wire        drive_selected,
  input  wire [5:0]  unit_status,
  input  wire [8:0]  selected_status,
  output wire        clock_phase_one,
  output wire        clock_phase_two,
  output reg         execute_enable_strobe,
  output reg         keypoint_test_point_n,
  output reg         end_of_director,
  output reg         end_of_director_clear,
  output reg         operation_done_indication,
  output reg         next_director_request,
  output wire        request_block,
  output reg         request_honored,
  output reg         operand_to_bus_enable,
  output reg         selected_status_gate,
  output reg         unit_status_gate,
  output reg         status_write_strobe,
  output reg         regfile_memory_enable,
  output reg         regfile_upper_enable,
  output reg         regfile_write_enable,
  output reg         regfile_lower_write,
  output reg  [3:0]  regfile_address,
  output reg  [15:0] regfile_bus_out,
  output reg         regfile_bus_drive,
  output reg  [15:0] catch_register,
  output reg         divide_poly_low_load,
  output reg         divide_poly_high_load,
  output reg         multiply_poly_low_load,
  output reg         multiply_poly_high_load,
  output reg  [31:0] divide_polynomial,
  output reg  [31:0] multiply_polynomial,
  output reg         hw_conditions_load,
  output reg         checkword_preset,
  output reg         eight_bit_mode,
  output reg         zero_fill_enable,
  output reg  [4:0]  sector_notch_count
);

  // Sequencer states
  localparam [2:0] ST_IDLE   = 3'd0; // Waiting for a decoded director
  localparam [2:0] ST_LRF_BUS = 3'd1; // Load RF: wait phase two to drive bus
  localparam [2:0] ST_LRF_WR = 3'd2; // Load RF: wait phase two to write
  localparam [2:0] ST_LRF_CLR = 3'd3; // Load RF: wait next phase pair
  localparam [2:0] ST_HONOR  = 3'd4; // Short director: wait phase two
  localparam [2:0] ST_HEND   = 3'd5; // Short director: raise end flags
  localparam [2:0] ST_COPY   = 3'd6; // Copy status timing chain running
  localparam [2:0] ST_EOD    = 3'd7; // End flag up, wait phase one

  reg        phase;             // Low in phase one, high in phase two
  reg  [2:0] state;             // Sequencer state
  reg        load_rf_pending;   // Load register file flip-flop
  reg        op_done;           // Director operation done flip-flop
  reg        unit_hold;         // Bit 24 holding flip-flop
  reg        copy_active;       // Copy disk status flip-flop
  reg  [3:0] copy_count;        // Internal clock pulses since copy start
  reg  [1:0] kp_count;          // Test point low time remaining
  reg  [31:0] dir;              // Director captured at decode
  reg  [7:0] pend_fn;           // Function awaiting the execute strobe
  reg        pend;              // Execute strobe due next cycle
  wire       ph1;
  wire       ph2;

  // True when the function code is one this block executes
  function is_ours;
    input [7:0] fn;
    begin
      is_ours = (fn == `SDE_FN_LOAD_RF) || (fn == `SDE_FN_KEYPOINT) ||
                (fn == `SDE_FN_LOAD_POLY) || (fn == `SDE_FN_LOAD_HW) ||
                (fn == `SDE_FN_COPY_STAT);
    end
  endfunction

  // Status word assembly; unit bits only when held, nothing without a drive
  function [15:0] status_word;
    input       sel;
    input       hold;
    input [5:0] unit;
    input [8:0] group;
    reg   [15:0] w;
    begin
      w = `SDE_ZERO16;
      w[`SDE_ST_SEL_HI:`SDE_ST_SEL_LO] = group; // R19
      if (hold)
        w[`SDE_ST_UNIT_HI:`SDE_ST_UNIT_LO] = unit; // R17 R18
      status_word = sel ? w : `SDE_ZERO16; // R20
    end
  endfunction

  // Two phases alternate on successive system clocks
  assign ph1             = ~phase; // R25
  assign ph2             = phase; // R25
  assign clock_phase_one = ph1;
  assign clock_phase_two = ph2;
  // A pending load holds off fetching of the next director
  assign request_block   = load_rf_pending; // R24

  // Phase divider: one step per phase keeps sequence timing exact
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      phase <= 1'b0;
    else
      phase <= ~phase;
  end

  // Decode stage: hold the director one cycle, then issue the strobe
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dir                   <= 32'h0000_0000;
      pend_fn               <= 8'h00;
      pend                  <= 1'b0;
      execute_enable_strobe <= 1'b0;
    end else begin
      execute_enable_strobe <= pend;
      pend                  <= 1'b0;
      // Only accept a director while the sequencer is free
      if (function_director_decoded && state == ST_IDLE && !pend &&
          !execute_enable_strobe &&
          is_ours(director_word[`SDE_FN_HI:`SDE_FN_LO])) begin
        dir     <= director_word;
        pend_fn <= director_word[`SDE_FN_HI:`SDE_FN_LO];
        pend    <= 1'b1;
      end
    end
  end

  // Keypoint test point: active low for SDE_KP_CYCLES clocks, twice the strobe width
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      kp_count              <= 2'd0;
      keypoint_test_point_n <= 1'b1;
    end else if (pend && pend_fn == `SDE_FN_KEYPOINT) begin
      kp_count              <= `SDE_KP_HOLD; // R05
      keypoint_test_point_n <= 1'b0; // R05
    end else if (kp_count != 2'd0) begin
      kp_count <= kp_count - 2'd1;
    end else begin
      keypoint_test_point_n <= 1'b1;
    end
  end

  // Strobe-time loads: catch register, polynomials, hardware conditions
  // The catch register is loaded with the strobe so it is stable when
  // the test point rises again.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      catch_register          <= `SDE_ZERO16;
      divide_polynomial       <= 32'h0000_0000;
      multiply_polynomial     <= 32'h0000_0000;
      divide_poly_low_load    <= 1'b0;
      divide_poly_high_load   <= 1'b0;
      multiply_poly_low_load  <= 1'b0;
      multiply_poly_high_load <= 1'b0;
      hw_conditions_load      <= 1'b0;
      checkword_preset        <= 1'b0;
      eight_bit_mode          <= 1'b0;
      zero_fill_enable        <= 1'b0;
      sector_notch_count      <= `SDE_ZERO5;
    end else begin
      divide_poly_low_load    <= 1'b0;
      divide_poly_high_load   <= 1'b0;
      multiply_poly_low_load  <= 1'b0;
      multiply_poly_high_load <= 1'b0;
      hw_conditions_load      <= 1'b0;
      if (execute_enable_strobe) begin
        case (pend_fn)
          `SDE_FN_KEYPOINT: begin
            catch_register <= dir[`SDE_OPND_HI:`SDE_OPND_LO]; // R04
          end
          `SDE_FN_LOAD_POLY: begin
            // Each select is independent, so all four may load at once
            divide_poly_low_load    <= dir[`SDE_SEL_DIV_LO]; // R07 R08 R09
            divide_poly_high_load   <= dir[`SDE_SEL_DIV_HI]; // R08 R09
            multiply_poly_low_load  <= dir[`SDE_SEL_MUL_LO]; // R08 R09
            multiply_poly_high_load <= dir[`SDE_SEL_MUL_HI]; // R08 R09
            if (dir[`SDE_SEL_DIV_LO])
              divide_polynomial[15:0] <= dir[`SDE_OPND_HI:`SDE_OPND_LO]; // R08
            if (dir[`SDE_SEL_DIV_HI])
              divide_polynomial[31:16] <= dir[`SDE_OPND_HI:`SDE_OPND_LO]; // R08
            if (dir[`SDE_SEL_MUL_LO])
              multiply_polynomial[15:0] <= dir[`SDE_OPND_HI:`SDE_OPND_LO]; // R08
            if (dir[`SDE_SEL_MUL_HI])
              multiply_polynomial[31:16] <= dir[`SDE_OPND_HI:`SDE_OPND_LO]; // R08
          end
          `SDE_FN_LOAD_HW: begin
            hw_conditions_load <= 1'b1; // R10 R15
            checkword_preset   <= dir[`SDE_HW_PRESET]; // R11 R15
            eight_bit_mode     <= dir[`SDE_HW_BYTE8]; // R12 R15
            zero_fill_enable   <= dir[`SDE_HW_ZFILL]; // R13 R15
            sector_notch_count <= dir[`SDE_NOTCH_HI:`SDE_NOTCH_LO]; // R14 R15
          end
          default: begin
            // Other directors load nothing here
          end
        endcase
      end
    end
  end

  // Main sequencer for the closing steps of each director
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state                     <= ST_IDLE;
      load_rf_pending           <= 1'b0;
      op_done                   <= 1'b0;
      operand_to_bus_enable     <= 1'b0;
      operation_done_indication <= 1'b0;
      next_director_request     <= 1'b0;
      request_honored           <= 1'b0;
      end_of_director           <= 1'b0;
      end_of_director_clear     <= 1'b0;
      regfile_memory_enable     <= 1'b1;
      regfile_upper_enable      <= 1'b0;
      regfile_write_enable      <= 1'b0;
      regfile_lower_write       <= 1'b0;
      regfile_address           <= `SDE_ZERO4;
      regfile_bus_out           <= `SDE_ZERO16;
      regfile_bus_drive         <= 1'b0;
      unit_hold                 <= 1'b0;
      copy_active               <= 1'b0;
      copy_count                <= `SDE_ZERO4;
      selected_status_gate      <= 1'b0;
      unit_status_gate          <= 1'b0;
      status_write_strobe       <= 1'b0;
    end else begin
      // Single-cycle outputs fall by default
      next_director_request     <= 1'b0;
      operation_done_indication <= 1'b0;
      regfile_write_enable      <= 1'b0;
      regfile_upper_enable      <= 1'b0;
      regfile_lower_write       <= 1'b0;
      status_write_strobe       <= 1'b0;
      // Companion flip-flop clocks itself clear once the end flag drops
      if (end_of_director_clear && !end_of_director)
        end_of_director_clear <= 1'b0; // R03
      case (state)
        ST_IDLE: begin
          if (execute_enable_strobe) begin
            case (pend_fn)
              `SDE_FN_LOAD_RF: begin
                load_rf_pending <= 1'b1; // R24
                regfile_address <= dir[`SDE_ADDR_HI:`SDE_ADDR_LO];
                state           <= ST_LRF_BUS;
              end
              `SDE_FN_COPY_STAT: begin
                regfile_address <= dir[`SDE_ADDR_HI:`SDE_ADDR_LO]; // R16
                unit_hold       <= dir[`SDE_UNIT_EN]; // R17
                copy_active     <= 1'b1; // R16
                copy_count      <= `SDE_ZERO4;
                state           <= ST_COPY;
              end
              default: begin
                request_honored <= 1'b1; // R06 R15
                state           <= ST_HONOR;
              end
            endcase
          end
        end
        ST_LRF_BUS: begin
          // Float the read path and put the operand on the bus
          if (ph2) begin
            operand_to_bus_enable <= 1'b1; // R23
            regfile_memory_enable <= 1'b0; // R23
            regfile_bus_out       <= dir[`SDE_OPND_HI:`SDE_OPND_LO]; // R23
            regfile_bus_drive     <= 1'b1; // R23
            state                 <= ST_LRF_WR;
          end
        end
        ST_LRF_WR: begin
          if (ph2) begin
            op_done                   <= 1'b1; // R01
            regfile_memory_enable     <= 1'b1; // R01
            regfile_upper_enable      <= 1'b1; // R01
            regfile_write_enable      <= 1'b1; // R01
            regfile_lower_write       <= 1'b1; // R01
            next_director_request     <= 1'b1; // R01
            operation_done_indication <= 1'b1; // R01
            load_rf_pending           <= 1'b0; // R01
            state                     <= ST_LRF_CLR;
          end
        end
        ST_LRF_CLR: begin
          // Phase one passes, the following phase two finishes the pair
          if (ph2) begin
            operand_to_bus_enable <= 1'b0; // R02
            op_done               <= 1'b0; // R02
            regfile_bus_drive     <= 1'b0; // R02
            end_of_director       <= 1'b1; // R02
            end_of_director_clear <= 1'b1; // R02
            state                 <= ST_EOD;
          end
        end
        ST_HONOR: begin
          if (ph2) begin
            op_done                   <= 1'b1; // R06
            request_honored           <= 1'b0; // R06
            operation_done_indication <= 1'b1; // R06
            state                     <= ST_HEND;
          end
        end
        ST_HEND: begin
          op_done               <= 1'b0; // R06
          end_of_director       <= 1'b1; // R06
          end_of_director_clear <= 1'b1; // R06
          state                 <= ST_EOD;
        end
        ST_COPY: begin
          // Chain advances on internal clock pulses of phase one
          if (ph1) begin
            copy_count <= copy_count + 4'h1;
            if (copy_count + 4'h1 == `SDE_COPY_GATE) begin
              regfile_memory_enable <= 1'b0; // R21
              selected_status_gate  <= 1'b1; // R21
              unit_status_gate      <= unit_hold; // R21
              regfile_bus_out       <= status_word(drive_selected, unit_hold,
                                                   unit_status, selected_status);
              regfile_bus_drive     <= 1'b1; // R21
            end else if (copy_count + 4'h1 == `SDE_COPY_WRITE) begin
              status_write_strobe   <= 1'b1; // R22
              regfile_write_enable  <= 1'b1; // R22
              regfile_upper_enable  <= 1'b1; // R22
              regfile_lower_write   <= 1'b1; // R22
              regfile_memory_enable <= 1'b1;
              copy_active           <= 1'b0; // R22
              end_of_director       <= 1'b1; // R22
              end_of_director_clear <= 1'b1; // R22
              state                 <= ST_EOD;
            end
          end
        end
        ST_EOD: begin
          // Bus is released once the written word has been taken
          selected_status_gate <= 1'b0;
          unit_status_gate     <= 1'b0;
          regfile_bus_drive    <= 1'b0;
          if (ph1) begin
            end_of_director <= 1'b0; // R03
            state           <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### bench/sde_drive_model.sv
// Model of the selected disk drive status lines facing the executor
`timescale 1ns/1ns
`default_nettype none
module sde_drive_model (
  input  wire logic       clk,
  input  wire logic       unit_on,
  input  wire logic [5:0] unit_value,
  input  wire logic [8:0] group_value,
  output var  logic       drive_selected,
  output var  logic [5:0] unit_status,
  output var  logic [8:0] selected_status
);
  logic [14:0] junk = 15'h5a3c;  // Filler shown while no unit is selected
  // Filler moves every cycle so an unselected drive never shows a stale value
  always @(posedge clk) begin
    junk <= {junk[13:0], junk[14] ^ junk[13]};
  end
  // Lines follow the drive only while it is selected
  always @* begin
    drive_selected  = unit_on;
    unit_status     = unit_on ? unit_value : junk[5:0];
    selected_status = unit_on ? group_value : junk[14:6];
  end
endmodule
`default_nettype wire

// ### bench/sde_executor_properties.sv
// Concurrent checks on the executor ports
`timescale 1ns/1ns
`default_nettype none
module sde_executor_properties (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [31:0] director_word,
  input wire logic        drive_selected,
  input wire logic        clock_phase_one,
  input wire logic        clock_phase_two,
  input wire logic        keypoint_test_point_n,
  input wire logic        end_of_director,
  input wire logic        end_of_director_clear,
  input wire logic        operation_done_indication,
  input wire logic        next_director_request,
  input wire logic        request_block,
  input wire logic        request_honored,
  input wire logic        operand_to_bus_enable,
  input wire logic        selected_status_gate,
  input wire logic        status_write_strobe,
  input wire logic        regfile_memory_enable,
  input wire logic        regfile_write_enable,
  input wire logic [15:0] regfile_bus_out,
  input wire logic        regfile_bus_drive,
  input wire logic [15:0] catch_register,
  input wire logic        divide_poly_low_load,
  input wire logic        multiply_poly_high_load,
  input wire logic [31:0] divide_polynomial,
  input wire logic [31:0] multiply_polynomial,
  input wire logic        hw_conditions_load,
  input wire logic        eight_bit_mode,
  input wire logic [4:0]  sector_notch_count
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  phase_pair_a: assert property (clock_phase_one != clock_phase_two)
    else $error("phases not complementary");
  phase_toggle_a: assert property (clock_phase_one |=> !clock_phase_one)
    else $error("phase one did not alternate");
  kp_width_a: assert property ($fell(keypoint_test_point_n) |=>
    !keypoint_test_point_n ##1 keypoint_test_point_n) else $error("test point width wrong");
  kp_catch_a: assert property ($rose(keypoint_test_point_n) |->
    catch_register == director_word[23:8]) else $error("catch not held at pulse end");
  poly_div_a: assert property (divide_poly_low_load |-> director_word[25] &&
    divide_polynomial[15:0] == director_word[23:8]) else $error("divide low load wrong");
  poly_mul_a: assert property (multiply_poly_high_load |-> director_word[28] &&
    multiply_polynomial[31:16] == director_word[23:8]) else $error("multiply high load wrong");
  hw_load_a: assert property (hw_conditions_load |-> request_honored &&
    eight_bit_mode == director_word[12] && sector_notch_count == director_word[20:16])
    else $error("hardware capture wrong");
  honored_end_a: assert property ($fell(request_honored) |-> operation_done_indication)
    else $error("honored dropped without done");
  eod_short_a: assert property ($rose(end_of_director) |-> end_of_director_clear
    ##[1:2] !end_of_director) else $error("end flag held too long");
  lrf_write_a: assert property (regfile_write_enable && operand_to_bus_enable |->
    regfile_bus_out == director_word[23:8] && next_director_request)
    else $error("load write without operand or request");
  block_a: assert property (request_block |-> !next_director_request)
    else $error("request raised while blocked");
  gate_bus_a: assert property ($rose(selected_status_gate) |->
    regfile_bus_drive && !regfile_memory_enable) else $error("status gated without bus");
  copy_end_a: assert property (status_write_strobe |-> end_of_director &&
    regfile_write_enable) else $error("status write without end");
  no_drive_a: assert property (status_write_strobe && !drive_selected |->
    regfile_bus_out == 16'h0000) else $error("status not zero without drive");
endmodule
bind sde_executor sde_executor_properties props (.*);
`default_nettype wire

// ### bench/support_director_executor_tb_top.sv
// Self-checking bench for the support director executor
`timescale 1ns/1ns
`default_nettype none
module support_director_executor_tb_top;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        function_director_decoded = 1'b0;
  logic [31:0] director_word = 32'h0000_0000;
  logic        unit_on = 1'b0;      // Drive selection commanded to the model
  logic [5:0]  unit_value = 6'h00;
  logic [8:0]  group_value = 9'h000;
  wire drive_selected, clock_phase_one, clock_phase_two, execute_enable_strobe;
  wire keypoint_test_point_n, end_of_director, end_of_director_clear, request_block;
  wire operation_done_indication, next_director_request, request_honored;
  wire operand_to_bus_enable, selected_status_gate, unit_status_gate, status_write_strobe;
  wire regfile_memory_enable, regfile_upper_enable, regfile_write_enable;
  wire regfile_lower_write, regfile_bus_drive, divide_poly_low_load, divide_poly_high_load;
  wire multiply_poly_low_load, multiply_poly_high_load, hw_conditions_load;
  wire checkword_preset, eight_bit_mode, zero_fill_enable;
  wire [3:0]  regfile_address;
  wire [4:0]  sector_notch_count;
  wire [5:0]  unit_status;
  wire [8:0]  selected_status;
  wire [15:0] regfile_bus_out, catch_register;
  wire [31:0] divide_polynomial, multiply_polynomial;
  // Events a scenario may wait on, by index
  wire [3:0] ev = {end_of_director, status_write_strobe, regfile_write_enable,
    execute_enable_strobe};
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] exp_div = 32'h0000_0000;  // Polynomials as the selects should leave them
  logic [31:0] exp_mul = 32'h0000_0000;
  logic [3:0]  psel [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF, 4'h5, 4'hA};
  sde_executor dut (.*);
  sde_drive_model drive (.*);
  always #25 clk = ~clk;
  // A hang is cut short well beyond the expected run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Sample just after an edge so its updates have landed
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic wait_ev(input int k);
    int n;
    n = 0;
    #1;
    while (ev[k] !== 1'b1 && n < 40) begin
      step();
      n = n + 1;
    end
    if (n == 40) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED event %0d expected 1 seen 0", k);
    end
  endtask
  // Word is held until the next offer, as the read chain would
  task automatic offer(input logic [31:0] w);
    @(posedge clk);
    function_director_decoded <= 1'b1;
    director_word <= w;
    @(posedge clk);
    function_director_decoded <= 1'b0;
  endtask
  task automatic finish_dir();
    wait_ev(3);
    check("eod companion", 32'(end_of_director_clear), 32'h1);
    step();
    step();
    check("eod fell", 32'(end_of_director), 32'h0);
  endtask
  task automatic t_refuse();
    offer(32'h0000_0055);
    repeat (6) begin
      step();
      check("bad code", 32'(execute_enable_strobe), 32'h0);
    end
  endtask
  task automatic t_load_rf(input logic [3:0] a, input logic [15:0] d);
    offer({a, 4'h0, d, 8'h80});
    wait_ev(0);
    step();
    check("rf block", 32'(request_block), 32'h1);
    wait_ev(1);
    check("rf data", 32'(regfile_bus_out), 32'(d));
    check("rf addr", 32'(regfile_address), 32'(a));
    check("rf done", 32'(operation_done_indication), 32'h1);
    check("rf strobes", 32'({regfile_upper_enable, regfile_lower_write}), 32'h3);
    check("rf read mode", 32'(regfile_memory_enable), 32'h1);
    finish_dir();
  endtask
  task automatic t_keypoint(input logic [15:0] d);
    offer({8'h00, d, 8'h8A});
    wait_ev(0);
    step();
    check("kp pulse", 32'(keypoint_test_point_n), 32'h0);
    check("kp catch", 32'(catch_register), 32'(d));
    check("kp honored", 32'(request_honored), 32'h1);
    finish_dir();
  endtask
  task automatic t_poly(input logic [3:0] s, input logic [15:0] d);
    if (s[0]) exp_div[15:0] = d;
    if (s[1]) exp_div[31:16] = d;
    if (s[2]) exp_mul[15:0] = d;
    if (s[3]) exp_mul[31:16] = d;
    offer({3'b000, s, 1'b0, d, 8'h84});
    wait_ev(0);
    step();
    check("poly loads", 32'({multiply_poly_high_load, multiply_poly_low_load,
      divide_poly_high_load, divide_poly_low_load}), 32'(s));
    finish_dir();
    check("poly divide", divide_polynomial, exp_div);
    check("poly multiply", multiply_polynomial, exp_mul);
  endtask
  task automatic t_hw(input logic p, input logic b, input logic z, input logic [4:0] n);
    offer({11'h000, n, z, 2'b00, b, p, 3'b000, 8'h86});
    wait_ev(0);
    step();
    check("hw strobe", 32'(hw_conditions_load), 32'h1);
    finish_dir();
    check("hw preset", 32'(checkword_preset), 32'(p));
    check("hw width", 32'(eight_bit_mode), 32'(b));
    check("hw fill", 32'(zero_fill_enable), 32'(z));
    check("hw notch", 32'(sector_notch_count), 32'(n));
  endtask
  task automatic t_copy(input logic [3:0] a, input logic u24, input logic on,
    input logic [5:0] u, input logic [8:0] g);
    @(posedge clk);
    unit_on <= on;
    unit_value <= u;
    group_value <= g;
    offer({a, 3'b000, u24, 16'h0000, 8'h88});
    wait_ev(2);
    check("cs word", 32'(regfile_bus_out),
      on ? {16'h0000, g, 1'b0, u24 ? u : 6'h00} : 32'h0000_0000);
    check("cs addr", 32'(regfile_address), 32'(a));
    check("cs unit gate", 32'(unit_status_gate), 32'(u24));
    finish_dir();
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    step();
    check("tp idle", 32'(keypoint_test_point_n), 32'h1);
    check("rf idle", 32'(regfile_memory_enable), 32'h1);
    t_refuse();
    t_load_rf(4'hF, 16'hA5C3);
    t_load_rf(4'h0, 16'h5A3C);
    t_keypoint(16'hBEEF);
    t_keypoint(16'h0001);
    for (int i = 0; i < 8; i++) t_poly(psel[i], 16'h1230 + 16'(i));
    t_hw(1'b1, 1'b0, 1'b1, 5'h00);
    t_hw(1'b0, 1'b1, 1'b0, 5'h1F);
    t_copy(4'hB, 1'b1, 1'b1, 6'h2D, 9'h15A);
    t_copy(4'h3, 1'b0, 1'b1, 6'h3F, 9'h0A5);
    t_copy(4'h6, 1'b1, 1'b0, 6'h3F, 9'h1FF);
    give_verdict();
  end
endmodule
`default_nettype wire
